// file: shared/adc_ctrl_consts.svh
// Purpose: Offsets, fields, reset values and counts of the converter control block
// Assumes: 32-bit APB, one register per aligned word
// Notes:   Byte addresses are relative to the block base
`ifndef ADC_CTRL_CONSTS_SVH
`define ADC_CTRL_CONSTS_SVH

`define ADC_SCR_ADDR      12'h000
`define ADC_RESULT_ADDR   12'h004
`define ADC_CLKSEL_ADDR   12'h008

`define ADC_SCR_RESET     8'h1f
`define ADC_CLKSEL_RESET  8'h00

`define ADC_POWER_OFF     5'h1f
`define ADC_HIGH_REF      5'h1d
`define ADC_LOW_REF       5'h1e
`define ADC_EXT_CHANNELS  5'h0c

`define ADC_CONV_TICKS    5'h10
`define ADC_DIV_MAX_LOG2  3'h4

`endif

// file: shared/adc_ctrl_pkg.sv
// Purpose: Types shared by the converter control block and its bench
// Assumes: Field layout as in adc_ctrl_consts.svh
// Notes:   Bit 7 of the status/control word is the completion flag
package adc_ctrl_pkg;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ARMED,
        ST_CONVERT
    } conv_state_t;

    typedef struct packed {
        logic       flag;
        logic       irqEnable;
        logic       continuous;
        logic [4:0] inputSelect;
    } status_control_t;

    typedef struct packed {
        logic [2:0] divide;
        logic       source;
        logic [3:0] spare;
    } clock_select_t;

    typedef struct packed {
        logic       start;
        logic       powerDown;
        logic       refHigh;
        logic       refLow;
        logic [4:0] channel;
    } analog_ctrl_t;

endpackage

// file: core/adc_control_and_clock_select.sv
// Purpose: Control, clocking and result capture of an 8-bit SAR converter
// Assumes: APB slave on ref_clk; analog result valid at the last converter tick
// Notes:   Oscillator clock is sampled, so it must be well below ref_clk / 2
`include "adc_ctrl_consts.svh"
`timescale 1ns/1ps

module adc_control_and_clock_select (
    input  wire logic                      ref_clk,
    input  wire logic                      rst_n,
    input  wire logic [11:0]               paddr,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire logic                      oscillator_clock,
    input  wire logic [7:0]                convResult,
    output adc_ctrl_pkg::analog_ctrl_t     analogCtrl,
    output logic                           completionIrq,
    output logic      [11:0]               pinInputForce
);

    adc_ctrl_pkg::status_control_t scr;
    adc_ctrl_pkg::status_control_t next_scr;
    adc_ctrl_pkg::clock_select_t   clkSel;
    adc_ctrl_pkg::clock_select_t   next_clkSel;
    adc_ctrl_pkg::conv_state_t     state;
    adc_ctrl_pkg::conv_state_t     next_state;
    adc_ctrl_pkg::analog_ctrl_t    next_analogCtrl;
    logic [7:0]  result;
    logic [7:0]  next_result;
    logic [31:0] next_prdata;
    logic        next_completionIrq;
    logic [11:0] next_pinInputForce;
    logic [4:0]  tickCount;
    logic [4:0]  next_tickCount;
    logic [3:0]  divCount;
    logic [3:0]  next_divCount;
    logic [3:0]  divLimit;
    logic [2:0]  divLog2;
    logic        oscMeta;
    logic        oscSync;
    logic        oscLast;
    logic        oscRise;
    logic        srcTick;
    logic        convTick;
    logic        access;
    logic        mapped;
    logic        scrWrite;
    logic        clkSelWrite;
    logic        resultRead;
    logic        done;
    logic        clearEvent;

    // APB decode; zero wait states, read data prepared in the setup cycle
    assign access      = psel && penable;
    assign pready      = 1'b1;
    assign mapped      = (paddr == `ADC_SCR_ADDR) || (paddr == `ADC_RESULT_ADDR)
                         || (paddr == `ADC_CLKSEL_ADDR);
    assign pslverr     = access && !mapped;
    assign scrWrite    = access && pwrite && (paddr == `ADC_SCR_ADDR);
    assign clkSelWrite = access && pwrite && (paddr == `ADC_CLKSEL_ADDR);
    assign resultRead  = access && !pwrite && (paddr == `ADC_RESULT_ADDR);
    assign clearEvent  = scrWrite || resultRead;

    always_comb begin
        next_prdata = prdata;
        if (psel && !penable && !pwrite) begin
            if (paddr == `ADC_SCR_ADDR) begin
                next_prdata = {24'h000000, scr};
            end else if (paddr == `ADC_RESULT_ADDR) begin
                next_prdata = {24'h000000, result};
            end else if (paddr == `ADC_CLKSEL_ADDR) begin
                next_prdata = {24'h000000, clkSel};
            end else begin
                next_prdata = 32'h00000000;
            end
        end
    end

    // Oscillator comes from outside this domain; edges are found after two flops
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            oscMeta <= 1'b0;
            oscSync <= 1'b0;
            oscLast <= 1'b0;
        end else begin
            oscMeta <= oscillator_clock;
            oscSync <= oscMeta;
            oscLast <= oscSync;
        end
    end

    assign oscRise = oscSync && !oscLast;
    assign srcTick = clkSel.source ? 1'b1 : oscRise;
    // Any divide code with the top bit set is treated as /16
    assign divLog2 = clkSel.divide[2] ? `ADC_DIV_MAX_LOG2 : clkSel.divide;
    assign divLimit = 4'((5'h01 << divLog2) - 5'h01);
    // A count left above a newly lowered limit ends the period at the next source tick instead of wrapping
    assign convTick = srcTick && (divCount >= divLimit);

    always_comb begin
        next_divCount = divCount;
        if (convTick) begin
            next_divCount = 4'h0;
        end else if (srcTick) begin
            next_divCount = divCount + 4'h1;
        end
    end

    // Completion is the sixteenth tick of a running conversion
    assign done = (state == adc_ctrl_pkg::ST_CONVERT) && convTick
                  && (tickCount == `ADC_CONV_TICKS - 5'h01);

    always_comb begin
        next_state     = state;
        next_tickCount = tickCount;
        next_result    = result;
        next_analogCtrl = analogCtrl;
        next_analogCtrl.start = 1'b0;
        case (state)
            adc_ctrl_pkg::ST_IDLE: begin
            end
            adc_ctrl_pkg::ST_ARMED: begin
                if (convTick) begin
                    next_state     = adc_ctrl_pkg::ST_CONVERT;
                    next_tickCount = 5'h00;
                    next_analogCtrl.start = 1'b1;
                end
            end
            adc_ctrl_pkg::ST_CONVERT: begin
                if (done) begin
                    next_result    = convResult;
                    next_tickCount = 5'h00;
                    if (scr.continuous) begin
                        next_analogCtrl.start = 1'b1;
                    end else begin
                        next_state = adc_ctrl_pkg::ST_IDLE;
                    end
                end else if (convTick) begin
                    next_tickCount = tickCount + 5'h01;
                end
            end
            default: begin
                next_state = adc_ctrl_pkg::ST_IDLE;
            end
        endcase
        // A control write restarts; the power-off code abandons instead
        if (scrWrite) begin
            next_analogCtrl.start = 1'b0;
            if (pwdata[4:0] == `ADC_POWER_OFF) begin
                next_state = adc_ctrl_pkg::ST_IDLE;
            end else begin
                next_state = adc_ctrl_pkg::ST_ARMED;
            end
        end
        // Undefined codes still convert; the analog side decides what it sees
        next_analogCtrl.channel   = next_scr.inputSelect;
        next_analogCtrl.powerDown = next_scr.inputSelect == `ADC_POWER_OFF;
        next_analogCtrl.refHigh   = next_scr.inputSelect == `ADC_HIGH_REF;
        next_analogCtrl.refLow    = next_scr.inputSelect == `ADC_LOW_REF;
        next_pinInputForce = 12'h000;
        if (next_scr.inputSelect < `ADC_EXT_CHANNELS) begin
            next_pinInputForce = 12'(12'h001 << next_scr.inputSelect);
        end
    end

    // Flag and interrupt: a completion in the clearing cycle wins
    always_comb begin
        next_scr    = scr;
        next_clkSel = clkSel;
        if (scrWrite) begin
            next_scr.irqEnable   = pwdata[6];
            next_scr.continuous  = pwdata[5];
            next_scr.inputSelect = pwdata[4:0];
        end
        if (clkSelWrite) begin
            next_clkSel.divide = pwdata[7:5];
            next_clkSel.source = pwdata[4];
        end
        next_completionIrq = completionIrq;
        if (done && scr.irqEnable) begin
            next_completionIrq = 1'b1;
        end else if (clearEvent) begin
            next_completionIrq = 1'b0;
        end
        if (done && !scr.irqEnable) begin
            next_scr.flag = 1'b1;
        end else if (clearEvent) begin
            next_scr.flag = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            scr           <= adc_ctrl_pkg::status_control_t'(`ADC_SCR_RESET);
            clkSel        <= adc_ctrl_pkg::clock_select_t'(`ADC_CLKSEL_RESET);
            state         <= adc_ctrl_pkg::ST_IDLE;
            result        <= 8'h00;
            prdata        <= 32'h00000000;
            completionIrq <= 1'b0;
            tickCount     <= 5'h00;
            divCount      <= 4'h0;
            analogCtrl    <= '{start: 1'b0, powerDown: 1'b1, refHigh: 1'b0,
                               refLow: 1'b0, channel: 5'h1f};
            pinInputForce <= 12'h000;
        end else begin
            scr           <= next_scr;
            clkSel        <= next_clkSel;
            state         <= next_state;
            result        <= next_result;
            prdata        <= next_prdata;
            completionIrq <= next_completionIrq;
            tickCount     <= next_tickCount;
            divCount      <= next_divCount;
            analogCtrl    <= next_analogCtrl;
            pinInputForce <= next_pinInputForce;
        end
    end

    a_reset_single: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        !$past(rst_n) |-> !scr.continuous)
        else $error("continuous bit not clear after reset");

    a_reset_poweroff: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        !$past(rst_n) |-> scr.inputSelect == 5'h1f && analogCtrl.powerDown)
        else $error("select field not all ones after reset");

    a_single_stops: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        done && !scr.continuous && !scrWrite |=> state == adc_ctrl_pkg::ST_IDLE)
        else $error("single conversion did not stop");

    a_cont_restarts: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        done && scr.continuous && !scrWrite |=> analogCtrl.start
        && state == adc_ctrl_pkg::ST_CONVERT)
        else $error("continuous conversion did not restart");

    a_result_loads: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        done |=> result == $past(convResult))
        else $error("result not loaded at completion");

    a_poweroff_abort: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        scrWrite && pwdata[4:0] == 5'h1f |=> state == adc_ctrl_pkg::ST_IDLE
        && analogCtrl.powerDown && !analogCtrl.start)
        else $error("power-off write did not abandon conversion");

    a_start_tick: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        state == adc_ctrl_pkg::ST_ARMED && convTick && !scrWrite
        |=> analogCtrl.start ##1 !analogCtrl.start)
        else $error("start pulse missing after first tick");

    a_flag_sets: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        done && !scr.irqEnable |=> scr.flag && !$changed(completionIrq))
        else $error("completion flag not set");

    a_irq_clears: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        resultRead && !done |=> !completionIrq && !scr.flag)
        else $error("read did not clear completion");

    a_div_sixteen: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        clkSel.divide[2] && convTick |-> divCount == 4'hf)
        else $error("divide by sixteen wrong");

    a_osc_source: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        !clkSel.source && convTick |-> oscRise)
        else $error("tick without oscillator edge");

    a_pin_force: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        analogCtrl.channel < 5'h0c |-> pinInputForce[analogCtrl.channel[3:0]]
        && $onehot(pinInputForce))
        else $error("selected pin not forced to input");

endmodule

// file: tb/test_adc_control_and_clock_select.sv
// Purpose: Self-checking bench for the converter control block
// Assumes: Zero-wait APB slave; oscillator modelled at one eighth of ref_clk
// Notes:   Conversion length is timed from the start pulse to the interrupt
`include "adc_ctrl_consts.svh"
`timescale 1ns/1ps

module test_adc_control_and_clock_select;
    logic                       ref_clk = 1'b0;
    logic                       rst_n = 1'b0;
    logic [11:0]                paddr = 12'h000;
    logic                       psel = 1'b0;
    logic                       penable = 1'b0;
    logic                       pwrite = 1'b0;
    logic [31:0]                pwdata = 32'h0;
    logic [31:0]                prdata;
    logic                       pready;
    logic                       pslverr;
    logic [2:0]                 oscCnt = 3'h0;
    logic [7:0]                 convResult = 8'h3c;
    adc_ctrl_pkg::analog_ctrl_t analogCtrl;
    logic                       completionIrq;
    logic [11:0]                pinInputForce;
    int                         miscompares = 0;
    int                         nTests = 0;
    int                         cycles = 0;
    logic [31:0]                rd;
    logic                       err;
    int                         n;
    int                         s;

    adc_control_and_clock_select u_dut (
        .ref_clk          (ref_clk),
        .rst_n            (rst_n),
        .paddr            (paddr),
        .psel             (psel),
        .penable          (penable),
        .pwrite           (pwrite),
        .pwdata           (pwdata),
        .prdata           (prdata),
        .pready           (pready),
        .pslverr          (pslverr),
        .oscillator_clock (oscCnt[2]),
        .convResult       (convResult),
        .analogCtrl       (analogCtrl),
        .completionIrq    (completionIrq),
        .pinInputForce    (pinInputForce)
    );

    always #10 ref_clk = ~ref_clk;

    // Slow oscillator, well under a quarter of ref_clk for the edge detector
    always @(posedge ref_clk) begin
        oscCnt <= oscCnt + 3'h1;
    end

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 40000) begin
            miscompares++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", nTests, miscompares);
        if (miscompares == 0 && nTests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        nTests++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    // Holds the request until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdc(input logic [11:0] addr, input logic [31:0] exp);
        apb(1'b0, addr, 32'h0);
        check(rd, exp);
    endtask

    // Cycles from the start pulse to the raised interrupt; -1 if never started
    task automatic conv(input logic [7:0] scr, output int cnt);
        int k;
        apb(1'b1, `ADC_SCR_ADDR, {24'h0, scr});
        cnt = -1;
        for (k = 0; k < 400 && cnt < 0; k++) begin
            @(negedge ref_clk);
            if (analogCtrl.start === 1'b1) cnt = 0;
        end
        for (k = 0; k < 3000 && cnt >= 0 && completionIrq !== 1'b1; k++) begin
            @(negedge ref_clk);
            cnt++;
        end
    endtask

    task automatic count_starts(input int len, output int cnt);
        cnt = 0;
        repeat (len) begin
            @(negedge ref_clk);
            if (analogCtrl.start === 1'b1) cnt++;
        end
    endtask

    task automatic test_reset();
        rdc(`ADC_SCR_ADDR, 32'h1f);
        rdc(`ADC_CLKSEL_ADDR, 32'h0);
        check({31'h0, analogCtrl.powerDown}, 32'h1);
        apb(1'b1, `ADC_RESULT_ADDR, 32'h77);
        rdc(`ADC_RESULT_ADDR, 32'h0);
        apb(1'b0, 12'h00c, 32'h0);
        check({31'h0, err}, 32'h1);
    endtask

    task automatic test_divide();
        logic [2:0] d;
        int         i;
        int         e;
        // Throwaway conversion lets the analog side settle after leaving power-off
        conv(8'h45, n);
        for (i = 0; i < 6; i++) begin
            d = (i == 5) ? 3'h7 : 3'(i);
            e = int'(`ADC_CONV_TICKS) << ((i > 4) ? 4 : i);
            @(posedge ref_clk);
            convResult <= 8'h10 + 8'(i);
            apb(1'b1, `ADC_CLKSEL_ADDR, {24'h0, d, 1'b1, 4'h0});
            conv(8'h45, n);
            check(n, e);
            rdc(`ADC_RESULT_ADDR, 32'h10 + 32'(i));
            @(negedge ref_clk);
            check({31'h0, completionIrq}, 32'h0);
        end
        rdc(`ADC_CLKSEL_ADDR, 32'hf0);
    endtask

    task automatic test_oscillator();
        apb(1'b1, `ADC_CLKSEL_ADDR, 32'h0);
        conv(8'h45, n);
        // One converter tick per oscillator rise, eight ref_clk cycles apart
        check({31'h0, n >= 120 && n <= 136}, 32'h1);
    endtask

    task automatic test_flag();
        apb(1'b1, `ADC_CLKSEL_ADDR, 32'h10);
        apb(1'b1, `ADC_SCR_ADDR, 32'h07);
        repeat (40) @(negedge ref_clk);
        rdc(`ADC_SCR_ADDR, 32'h87);
        check({31'h0, completionIrq}, 32'h0);
        rdc(`ADC_RESULT_ADDR, 32'h15);
        rdc(`ADC_SCR_ADDR, 32'h07);
    endtask

    task automatic test_continuous();
        @(posedge ref_clk);
        convResult <= 8'h5a;
        apb(1'b1, `ADC_SCR_ADDR, 32'h25);
        count_starts(100, s);
        check({31'h0, s >= 6}, 32'h1);
        rdc(`ADC_RESULT_ADDR, 32'h5a);
        @(posedge ref_clk);
        convResult <= 8'ha5;
        repeat (40) @(negedge ref_clk);
        rdc(`ADC_RESULT_ADDR, 32'ha5);
        apb(1'b1, `ADC_SCR_ADDR, 32'h05);
        count_starts(100, s);
        check(s, 1);
    endtask

    task automatic test_mux();
        int i;
        for (i = 0; i < 12; i++) begin
            apb(1'b1, `ADC_SCR_ADDR, 32'(i));
            repeat (2) @(negedge ref_clk);
            check({20'h0, pinInputForce}, 32'h1 << i);
            check({27'h0, analogCtrl.channel}, 32'(i));
        end
        apb(1'b1, `ADC_SCR_ADDR, {27'h0, `ADC_HIGH_REF});
        repeat (2) @(negedge ref_clk);
        check({18'h0, analogCtrl.refHigh, analogCtrl.refLow, pinInputForce}, 32'h2000);
        apb(1'b1, `ADC_SCR_ADDR, {27'h0, `ADC_LOW_REF});
        repeat (2) @(negedge ref_clk);
        check({18'h0, analogCtrl.refHigh, analogCtrl.refLow, pinInputForce}, 32'h1000);
        apb(1'b1, `ADC_SCR_ADDR, 32'h0c);
        repeat (2) @(negedge ref_clk);
        check({18'h0, analogCtrl.refHigh, analogCtrl.refLow, pinInputForce}, 32'h0);
        check({27'h0, analogCtrl.channel}, 32'h0c);
    endtask

    task automatic test_poweroff();
        // Stop the conversion left running before touching the clock settings
        apb(1'b1, `ADC_SCR_ADDR, 32'h1f);
        apb(1'b1, `ADC_CLKSEL_ADDR, 32'h90);
        apb(1'b1, `ADC_SCR_ADDR, 32'h45);
        repeat (40) @(negedge ref_clk);
        // Abandon mid-conversion: no completion may follow
        apb(1'b1, `ADC_SCR_ADDR, 32'h5f);
        count_starts(300, s);
        check(s, 0);
        check({31'h0, completionIrq}, 32'h0);
        check({31'h0, analogCtrl.powerDown}, 32'h1);
        rdc(`ADC_SCR_ADDR, 32'h5f);
    endtask

    initial begin
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        test_reset();
        test_divide();
        test_oscillator();
        test_flag();
        test_continuous();
        test_mux();
        test_poweroff();
        tally_and_finish();
    end
endmodule
